// ===== orb_load_model.sv
// partner: open-drain loads with a pull-up resistor on every pin
`timescale 1ns/1ps
`default_nettype none
module orb_load_model
    import orb_pkg::*;
(
    input wire logic [NUM_PIN-1:0] i_pull_low,
    output logic [NUM_PIN-1:0] o_line
);
    // the pull-up wins whenever the driver lets go, so no stale level survives
    assign o_line = ~i_pull_low;
endmodule
`default_nettype wire

// ===== orb_pkg.sv
// package: register map, field layout and timing constants of the output routing/brake block
package orb_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam real MS_PER_S = 1000.0;
    localparam int MS_CYCLES = 50_000; // 1 ms at 50 MHz
    localparam int NUM_OUT = 4;
    localparam int NUM_PIN = NUM_OUT + 1;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_POL = 8'h04;
    localparam logic [7:0] A_MAN_EN = 8'h08;
    localparam logic [7:0] A_MAN_VAL = 8'h0C;
    localparam logic [7:0] A_ROUTE_EN = 8'h10;
    localparam logic [7:0] A_ROUTE0 = 8'h14;
    localparam logic [7:0] A_MODE = 8'h28;
    localparam logic [7:0] A_BRK_T1 = 8'h2C;
    localparam logic [7:0] A_BRK_T4 = 8'h38;
    localparam logic [7:0] A_BRK_FREQ = 8'h3C;
    localparam logic [7:0] A_BRK_DUTY = 8'h40;
    localparam logic [7:0] A_STATUS = 8'h44;
    localparam logic [7:0] A_CFG1 = 8'h48;
    localparam logic [7:0] A_CFG5 = 8'h4C;

    localparam int GEN_OUT_BASE = 16;
    localparam int BRAKE_BIT = 0;
    localparam int AUTO_BRAKE_BIT = 2;
    localparam int GATE_INV_BIT = 7;
    localparam logic [7:0] SRC_ONE = 8'h00;
    localparam logic [7:0] SRC_ZERO = 8'h01;
    localparam logic [7:0] SRC_ENC_LO = 8'h02;
    localparam logic [7:0] SRC_ENC_HI = 8'h08;
    localparam logic [7:0] SRC_POS_LO = 8'h09;
    localparam logic [7:0] SRC_POS_HI = 8'h0F;
    localparam logic [7:0] SRC_PWM = 8'h10;
    localparam logic [7:0] SRC_PWM_N = 8'h11;
    localparam int FAST_PINS = 3;
    localparam int FAST_HZ = 10_000;
    localparam int SLOW_HZ = 500;
    localparam int SLOW_CYCLES = CLK_HZ / SLOW_HZ / 2;

    localparam logic [15:0] FREQ_MAX = 16'h07D0; // 2000 Hz
    localparam logic [15:0] FREQ_MIN = 16'h0001;
    localparam logic [6:0] DUTY_MIN = 7'h02;
    localparam logic [6:0] DUTY_MAX = 7'h64;
    localparam logic [15:0] FREQ_RST = 16'h07D0;
    localparam logic [6:0] DUTY_RST = 7'h64;
    localparam logic [15:0] T_RST = 16'h0000;

    typedef struct packed {
        logic [7:0] src;
        logic gate_inv;
        logic [6:0] gate_bit;
    } orb_route_t;

    typedef struct packed {
        logic current_on;
        logic brake_released;
        logic motion_ok;
    } orb_drive_t;
endpackage

// ===== orb_top.sv
// file: output stage with polarity, manual override, routing, brake sequencer and brake PWM
// ==========================================================================
// Overview of operation
// RL1: general output n follows control word bit 15+n.
// RL2: control bits 0..15 are special; bit 0 drives the brake output.
// RL3: polarity bit clear gives high for one; set gives low.
// RL4: manual-override bit selects manual value word bit, brake included.
// RL5: first and fifth configuration entries do nothing.
// RL6: routing enable of one puts every output into routing mode.
// RL7: in routing mode polarity and manual override are ignored.
// RL8: five routing entries: brake, then outputs 1 to 4.
// RL9: entry upper byte selects source, lower byte selects gate bit.
// RL10: entry bit 7 inverts the gate sense.
// RL11: source 00 constant one, source 01 constant zero.
// RL12: sources 02..08 encoder pulses divided by 1..64.
// RL13: sources 09..0F position pulses divided by 1..64.
// RL14: source 10 brake PWM, source 11 inverted brake PWM.
// RL15: brake, outputs 1 and 2 fast; others limited to 500 Hz.
// RL16: automatic brake acts only in operation enabled; else engaged.
// RL17: mode bit 2 selects automatic brake, else control bit 0.
// RL18: enable: current on, delay 3, release, delay 4, allow motion.
// RL19: disable: stop, delay 1, engage, delay 2, current off.
// RL20: released brake carries PWM at set hertz, at most 2000.
// RL21: duty 2 to 100 percent; 100 holds output on.
// RL22: out-of-range frequency or duty writes are rejected.
// RL23: each delay counts milliseconds before the next step starts.
`timescale 1ns/1ps
`default_nettype none
module orb_top
    import orb_pkg::*;
#(
    parameter int MS_CNT = MS_CYCLES
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic I_OP_ENABLED,
    input wire logic I_ENC_PULSE,
    input wire logic I_POS_PULSE,
    input wire logic I_MOTOR_STOPPED,
    output logic [NUM_PIN-1:0] O_PIN_OE,
    output logic [NUM_PIN-1:0] O_PIN_LVL,
    output logic O_CURRENT_ON,
    output logic O_STOP_REQ,
    output logic O_MOTION_OK
);
    // ======================================================================
    // synchronisers
    // pins and the drive state come from outside this clock: two flops before use
    logic [2:0] sync1_r, sync2_r, prev_r;
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            prev_r <= 3'h0;
        end else begin
            sync1_r <= {I_OP_ENABLED, I_POS_PULSE, I_ENC_PULSE};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end
    wire logic op_en = sync2_r[2];
    wire logic enc_rise = sync2_r[0] && !prev_r[0];
    wire logic pos_rise = sync2_r[1] && !prev_r[1];

    logic stop_s1_r, stop_s2_r;
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            stop_s1_r <= 1'b0;
            stop_s2_r <= 1'b0;
        end else begin
            stop_s1_r <= I_MOTOR_STOPPED;
            stop_s2_r <= stop_s1_r;
        end
    end

    // ======================================================================
    // registers
    logic [31:0] ctrl_r, pol_r, man_en_r, man_val_r, mode_r, cfg1_r, cfg5_r;
    logic route_en_r;
    orb_route_t route_r [NUM_PIN];
    logic [15:0] t_r [4];
    logic [15:0] freq_r;
    logic [6:0] duty_r;
    logic brake_rel_r;
    typedef enum {S_OFF, S_D3, S_D4, S_ON, S_STOP, S_D1, S_D2} orb_state_t;
    orb_state_t st_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int n);
        hit = (a >= base) && (a < 8'(int'(base) + 4 * n)) && (a[1:0] == 2'h0);
    endfunction

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ctrl_r <= 32'h0;
            pol_r <= 32'h0;
            man_en_r <= 32'h0;
            man_val_r <= 32'h0;
            mode_r <= 32'h0;
            cfg1_r <= 32'h0;
            cfg5_r <= 32'h0;
            route_en_r <= 1'b0;
            freq_r <= FREQ_RST;
            duty_r <= DUTY_RST;
            for (int i = 0; i < NUM_PIN; i++) begin
                route_r[i] <= '0;
            end
            for (int i = 0; i < 4; i++) begin
                t_r[i] <= T_RST;
            end
        end else if (I_WR) begin
            case (I_ADDR)
                A_CTRL: ctrl_r <= I_WDATA;
                A_POL: pol_r <= I_WDATA;
                A_MAN_EN: man_en_r <= I_WDATA;
                A_MAN_VAL: man_val_r <= I_WDATA;
                A_ROUTE_EN: route_en_r <= I_WDATA[0]; // RL6
                A_MODE: mode_r <= I_WDATA;
                A_CFG1: cfg1_r <= I_WDATA; // RL5
                A_CFG5: cfg5_r <= I_WDATA; // RL5
                A_BRK_FREQ: begin
                    if (I_WDATA <= 32'(FREQ_MAX) && I_WDATA >= 32'(FREQ_MIN)) begin // RL22 RL20
                        freq_r <= I_WDATA[15:0];
                    end
                end
                A_BRK_DUTY: begin
                    if (I_WDATA <= 32'(DUTY_MAX) && I_WDATA >= 32'(DUTY_MIN)) begin // RL22 RL21
                        duty_r <= I_WDATA[6:0];
                    end
                end
                default: begin
                    for (int i = 0; i < NUM_PIN; i++) begin
                        if (I_ADDR == 8'(int'(A_ROUTE0) + 4 * i)) begin
                            route_r[i] <= orb_route_t'(I_WDATA[15:0]); // RL8 RL9
                        end
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (I_ADDR == 8'(int'(A_BRK_T1) + 4 * i)) begin
                            t_r[i] <= I_WDATA[15:0];
                        end
                    end
                end
            endcase
        end
    end

    // read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RDATA <= 32'h0;
        end else if (I_RD) begin
            O_RDATA <= 32'h0;
            case (I_ADDR)
                A_CTRL: O_RDATA <= ctrl_r;
                A_POL: O_RDATA <= pol_r;
                A_MAN_EN: O_RDATA <= man_en_r;
                A_MAN_VAL: O_RDATA <= man_val_r;
                A_ROUTE_EN: O_RDATA <= {31'h0, route_en_r};
                A_MODE: O_RDATA <= mode_r;
                A_CFG1: O_RDATA <= cfg1_r;
                A_CFG5: O_RDATA <= cfg5_r;
                A_BRK_FREQ: O_RDATA <= {16'h0, freq_r};
                A_BRK_DUTY: O_RDATA <= {25'h0, duty_r};
                A_STATUS: O_RDATA <= {24'h0, O_PIN_LVL, O_MOTION_OK, brake_rel_r, O_CURRENT_ON};
                default: begin
                    for (int i = 0; i < NUM_PIN; i++) begin
                        if (I_ADDR == 8'(int'(A_ROUTE0) + 4 * i)) begin
                            O_RDATA <= {16'h0, route_r[i]};
                        end
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (I_ADDR == 8'(int'(A_BRK_T1) + 4 * i)) begin
                            O_RDATA <= {16'h0, t_r[i]};
                        end
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // millisecond tick and brake sequencer
    logic [31:0] ms_div_r;
    logic ms_tick;
    orb_state_t st_d_r;
    logic seq_step;
    // a free-running tick would cut the first millisecond of a delay short,
    // so the divider restarts on every sequencer step and each delay lasts in full
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_d_r <= S_OFF;
        end else begin
            st_d_r <= st_r;
        end
    end
    assign seq_step = (st_r != st_d_r);

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ms_div_r <= 32'h0;
        end else if (seq_step) begin
            ms_div_r <= 32'h0; // RL23
        end else if (ms_div_r == 32'(MS_CNT - 1)) begin
            ms_div_r <= 32'h0;
        end else begin
            ms_div_r <= ms_div_r + 32'h1;
        end
    end
    assign ms_tick = !seq_step && (ms_div_r == 32'(MS_CNT - 1)); // RL23

    logic [15:0] wait_r;
    wire logic waited = (wait_r == 16'h0);
    orb_drive_t drv;
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_r <= S_OFF;
            wait_r <= 16'h0;
        end else begin
            if (!waited && ms_tick) begin
                wait_r <= wait_r - 16'h1; // RL23
            end
            case (st_r)
                S_OFF: if (op_en) begin
                    st_r <= S_D3;
                    wait_r <= t_r[2]; // RL18
                end
                S_D3: if (waited) begin
                    st_r <= S_D4;
                    wait_r <= t_r[3]; // RL18
                end
                S_D4: if (waited) begin
                    st_r <= S_ON;
                end
                S_ON: if (!op_en) begin
                    st_r <= S_STOP;
                end
                S_STOP: if (stop_s2_r) begin
                    st_r <= S_D1;
                    wait_r <= t_r[0]; // RL19
                end
                S_D1: if (waited) begin
                    st_r <= S_D2;
                    wait_r <= t_r[1]; // RL19
                end
                S_D2: if (waited) begin
                    st_r <= S_OFF;
                end
                default: st_r <= S_OFF;
            endcase
        end
    end

    always_comb begin
        drv.current_on = (st_r != S_OFF);
        drv.brake_released = (st_r == S_D4) || (st_r == S_ON) || (st_r == S_STOP)
            || (st_r == S_D1); // RL16
        drv.motion_ok = (st_r == S_ON);
    end
    assign O_CURRENT_ON = drv.current_on;
    assign O_MOTION_OK = drv.motion_ok;
    assign O_STOP_REQ = (st_r == S_STOP);

    // ======================================================================
    // brake PWM: period in clocks = CLK_HZ/freq, high part = period*duty/100
    logic [31:0] pwm_cnt_r, period_r, high_r;
    logic pwm_r;
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            period_r <= 32'h1;
            high_r <= 32'h1;
            pwm_cnt_r <= 32'h0;
            pwm_r <= 1'b0;
        end else begin
            // a divide on every clock is costly; a plain divider is kept for clarity
            // a frequency of zero is refused on write, so the divide never sees zero
            period_r <= 32'(CLK_HZ) / 32'(freq_r); // RL20
            high_r <= 32'((64'(period_r) * 64'(duty_r)) / 64'(DUTY_MAX)); // RL21
            pwm_cnt_r <= (pwm_cnt_r >= period_r - 32'h1) ? 32'h0 : pwm_cnt_r + 32'h1;
            pwm_r <= (duty_r == DUTY_MAX) || (pwm_cnt_r < high_r); // RL21
        end
    end

    // the sequencer owns the brake only in automatic mode; otherwise control bit 0 does
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            brake_rel_r <= 1'b0;
        end else if (mode_r[AUTO_BRAKE_BIT]) begin
            brake_rel_r <= drv.brake_released; // RL17 RL16
        end else begin
            brake_rel_r <= ctrl_r[BRAKE_BIT]; // RL17 RL2
        end
    end

    // ======================================================================
    // divided pulse sources: toggle per 2^(k-1) pulses, k=0 passes pulse through
    logic [6:0] enc_cnt_r, pos_cnt_r;
    logic enc_r, pos_r;
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            enc_cnt_r <= 7'h0;
            pos_cnt_r <= 7'h0;
        end else begin
            if (enc_rise) enc_cnt_r <= enc_cnt_r + 7'h1; // RL12
            if (pos_rise) pos_cnt_r <= pos_cnt_r + 7'h1; // RL13
        end
    end

    function automatic logic div_sel(input logic raw, input logic [6:0] cnt,
                                     input logic [2:0] k);
        div_sel = (k == 3'h0) ? raw : cnt[k-3'h1];
    endfunction

    // ======================================================================
    // output selection per pin; index 0 is the brake
    logic [NUM_PIN-1:0] lvl_nxt, lvl_r;
    logic slow_tick;
    logic [31:0] slow_cnt_r;
    always_comb begin
        logic [7:0] s;
        logic on;
        logic v;
        int cb;
        s = 8'h0;
        on = 1'b0;
        v = 1'b0;
        cb = 0;
        lvl_nxt = '0;
        for (int i = 0; i < NUM_PIN; i++) begin
            cb = (i == 0) ? BRAKE_BIT : GEN_OUT_BASE + i - 1; // RL1 RL2
            if (route_en_r) begin // RL6 RL7
                s = route_r[i].src;
                // only the low five gate bits can reach the 32-bit control word
                on = ctrl_r[route_r[i].gate_bit[4:0]] ^ route_r[i].gate_inv; // RL10
                if (s == SRC_ONE) v = 1'b1; // RL11
                else if (s == SRC_ZERO) v = 1'b0; // RL11
                else if (s <= SRC_ENC_HI) v = div_sel(sync2_r[0], enc_cnt_r, 3'(s - SRC_ENC_LO));
                else if (s <= SRC_POS_HI) v = div_sel(sync2_r[1], pos_cnt_r, 3'(s - SRC_POS_LO));
                else if (s == SRC_PWM) v = pwm_r; // RL14
                else if (s == SRC_PWM_N) v = !pwm_r; // RL14
                else v = 1'b0;
                lvl_nxt[i] = on && v;
            end else begin
                if (man_en_r[cb]) v = man_val_r[cb]; // RL4
                else if (i == 0) v = brake_rel_r && pwm_r; // RL20
                else v = ctrl_r[cb];
                lvl_nxt[i] = v ^ pol_r[cb]; // RL3
            end
        end
    end

    // slow pins update at most every SLOW_CYCLES, capping them near 500 Hz
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            slow_cnt_r <= 32'h0;
            lvl_r <= '0;
        end else begin
            slow_cnt_r <= (slow_cnt_r == 32'(SLOW_CYCLES - 1)) ? 32'h0 : slow_cnt_r + 32'h1;
            for (int i = 0; i < NUM_PIN; i++) begin
                if (i < FAST_PINS || slow_tick) lvl_r[i] <= lvl_nxt[i]; // RL15
            end
        end
    end
    assign slow_tick = (slow_cnt_r == 32'h0);
    // open drain: low level pulls, high level releases
    assign O_PIN_LVL = lvl_r;
    assign O_PIN_OE = ~lvl_r;
endmodule
`default_nettype wire

// ===== orb_top_props.sv
// checker: port-level properties of the output routing and brake block
`timescale 1ns/1ps
`default_nettype none
module orb_top_props
    import orb_pkg::*;
#(
    parameter int MS_CNT = MS_CYCLES
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_OP_ENABLED,
    input wire logic [NUM_PIN-1:0] O_PIN_OE,
    input wire logic [NUM_PIN-1:0] O_PIN_LVL,
    input wire logic O_CURRENT_ON,
    input wire logic O_STOP_REQ,
    input wire logic O_MOTION_OK
);
    logic [15:0] freq_r;
    logic [6:0] duty_r;
    logic freq_ok;
    logic duty_ok;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);
    // ==========================================================
    // shadow of accepted brake settings; rejected writes leave them
    assign freq_ok = I_WR && I_ADDR == A_BRK_FREQ && I_WDATA >= {16'h0, FREQ_MIN}
        && I_WDATA <= {16'h0, FREQ_MAX};
    assign duty_ok = I_WR && I_ADDR == A_BRK_DUTY && I_WDATA >= {25'h0, DUTY_MIN}
        && I_WDATA <= {25'h0, DUTY_MAX};
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            freq_r <= FREQ_RST;
            duty_r <= DUTY_RST;
        end else begin
            freq_r <= freq_ok ? I_WDATA[15:0] : freq_r;
            duty_r <= duty_ok ? I_WDATA[6:0] : duty_r;
        end
    end
    // ==========================================================
    // assertions
    a_oe_inverse: assert property (O_PIN_OE == ~O_PIN_LVL)
        else $error("pin enable is not the inverse of pin level");
    a_unmapped_read: assert property (I_RD && I_ADDR == 8'hFC |=> O_RDATA == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_freq_kept: assert property (I_RD && I_ADDR == A_BRK_FREQ |=> O_RDATA[15:0] == freq_r)
        else $error("brake frequency readback wrong");
    a_duty_kept: assert property (I_RD && I_ADDR == A_BRK_DUTY |=> O_RDATA[6:0] == duty_r)
        else $error("brake duty readback wrong");
    a_rdata_hold: assert property (!I_RD |=> $stable(O_RDATA))
        else $error("read data changed without a read");
    a_motion_current: assert property (O_MOTION_OK |-> O_CURRENT_ON)
        else $error("motion allowed without motor current");
    a_motion_after: assert property ($rose(O_MOTION_OK) |-> $past(O_CURRENT_ON))
        else $error("motion allowed before current was on");
    a_current_off_late: assert property ($fell(O_CURRENT_ON) |-> $past(!O_MOTION_OK))
        else $error("current dropped while motion allowed");
    a_stop_no_motion: assert property (O_STOP_REQ |-> !O_MOTION_OK)
        else $error("stop request while motion allowed");
    a_op_low_stops: assert property (!I_OP_ENABLED [*5] |-> !O_MOTION_OK)
        else $error("motion allowed outside operation enabled");
    cover property ($rose(O_MOTION_OK));
    cover property ($fell(O_CURRENT_ON));
    cover property (O_STOP_REQ && O_CURRENT_ON);
endmodule
bind orb_top orb_top_props #(.MS_CNT(MS_CNT)) props_u (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_OP_ENABLED(I_OP_ENABLED), .O_PIN_OE(O_PIN_OE), .O_PIN_LVL(O_PIN_LVL),
    .O_CURRENT_ON(O_CURRENT_ON), .O_STOP_REQ(O_STOP_REQ), .O_MOTION_OK(O_MOTION_OK));
`default_nettype wire

// ===== orb_top_test.sv
// testbench: registers, output logic, routing and brake sequencing
`timescale 1ns/1ps
`default_nettype none
module orb_top_test;
    import orb_pkg::*;
    localparam int MS = 50;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic op_en = 1'b0;
    logic enc = 1'b0;
    logic pos = 1'b0;
    logic stopped = 1'b0;
    logic [31:0] rdata;
    logic [NUM_PIN-1:0] oe;
    logic [NUM_PIN-1:0] lvl;
    logic [NUM_PIN-1:0] line;
    logic cur_on;
    logic stop_req;
    logic mot_ok;
    logic brake_v;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    orb_top #(.MS_CNT(MS)) dut_u (.I_CLOCK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_OP_ENABLED(op_en),
        .I_ENC_PULSE(enc), .I_POS_PULSE(pos), .I_MOTOR_STOPPED(stopped), .O_PIN_OE(oe),
        .O_PIN_LVL(lvl), .O_CURRENT_ON(cur_on), .O_STOP_REQ(stop_req), .O_MOTION_OK(mot_ok));
    orb_load_model load_u (.i_pull_low(oe), .o_line(line));
    always_comb brake_v = line[0];
    initial forever #10 clk = ~clk;
    // ==========================================================
    // shared tasks
    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pin_chk(input int p, input logic exp);
        repeat (6) @(negedge clk);
        chk({31'h0, line[p]}, {31'h0, exp});
    endtask
    // bounded wait, sampled away from the active edge
    task automatic wait_lvl(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk({27'h0, oe}, 32'h1F);
        chk({29'h0, cur_on, stop_req, mot_ok}, 32'h0);
        rd_chk(A_BRK_FREQ, 32'h7D0);
        rd_chk(A_BRK_DUTY, 32'h64);
        rd_chk(8'hFC, 32'h0);
        wr_reg(A_BRK_FREQ, 32'h7D1);
        rd_chk(A_BRK_FREQ, 32'h7D0);
        wr_reg(A_BRK_FREQ, 32'h0);
        rd_chk(A_BRK_FREQ, 32'h7D0);
        wr_reg(A_BRK_FREQ, 32'h3E8);
        rd_chk(A_BRK_FREQ, 32'h3E8);
        wr_reg(A_BRK_DUTY, 32'h65);
        wr_reg(A_BRK_DUTY, 32'h1);
        rd_chk(A_BRK_DUTY, 32'h64);
    endtask
    task automatic t_brake_seq();
        int n0;
        int n1;
        int n2;
        wr_reg(A_MODE, 32'h4);
        wr_reg(A_BRK_T1, 32'h1);
        wr_reg(A_BRK_T1 + 8'h04, 32'h1);
        wr_reg(A_BRK_T1 + 8'h08, 32'h2);
        wr_reg(A_BRK_T4, 32'h2);
        pin_chk(0, 1'b0);
        @(posedge clk);
        op_en <= 1'b1;
        wait_lvl(cur_on, 1'b1, n0);
        wait_lvl(brake_v, 1'b1, n1);
        chk({31'h0, mot_ok}, 32'h0);
        wait_lvl(mot_ok, 1'b1, n2);
        chk({31'h0, n1 >= 2 * MS && n1 <= 2 * MS + 4}, 32'h1);
        chk({31'h0, n2 >= 2 * MS - 2 && n2 <= 2 * MS + 4}, 32'h1);
        pin_chk(0, 1'b1);
        @(posedge clk);
        op_en <= 1'b0;
        wait_lvl(stop_req, 1'b1, n0);
        chk({31'h0, brake_v}, 32'h1);
        @(posedge clk);
        stopped <= 1'b1;
        wait_lvl(brake_v, 1'b0, n1);
        chk({31'h0, cur_on}, 32'h1);
        wait_lvl(cur_on, 1'b0, n2);
        chk({31'h0, n1 >= MS && n1 <= MS + 8}, 32'h1);
        chk({31'h0, n2 >= MS - 2 && n2 <= MS + 4}, 32'h1);
    endtask
    task automatic t_outputs();
        wr_reg(A_CTRL, 32'h0001_0000);
        pin_chk(1, 1'b1);
        pin_chk(2, 1'b0);
        wr_reg(A_CTRL, 32'h0002_0000);
        pin_chk(2, 1'b1);
        wr_reg(A_POL, 32'h0001_0000);
        pin_chk(1, 1'b1);
        wr_reg(A_CTRL, 32'h0001_0000);
        pin_chk(1, 1'b0);
        wr_reg(A_MODE, 32'h0);
        pin_chk(0, 1'b0);
        wr_reg(A_CTRL, 32'h0001_0001);
        pin_chk(0, 1'b1);
        wr_reg(A_MAN_EN, 32'h0002_0001);
        wr_reg(A_MAN_VAL, 32'h0002_0001);
        pin_chk(2, 1'b1);
        pin_chk(0, 1'b1);
        wr_reg(A_CFG1, 32'hFFFF_FFFF);
        wr_reg(A_CFG5, 32'hFFFF_FFFF);
        chk({27'h0, line}, 32'h05);
        rd_chk(A_STATUS, 32'h2A);
    endtask
    task automatic t_routing();
        logic [15:0] cfg [6] = '{16'h0005, 16'h0105, 16'h0006, 16'h0086, 16'h1005, 16'h1105};
        logic [5:0] exp = 6'b011001;
        logic p;
        wr_reg(A_CTRL, 32'h0000_0020);
        wr_reg(A_ROUTE_EN, 32'h1);
        pin_chk(0, 1'b0);
        wr_reg(A_ROUTE0, 32'h0005);
        pin_chk(0, 1'b1);
        for (int i = 0; i < 6; i++) begin
            wr_reg(A_ROUTE0 + 8'h04, {16'h0, cfg[i]});
            pin_chk(1, exp[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr_reg(A_ROUTE0 + 8'h08, i < 2 ? 32'h0205 : 32'h0905);
            @(posedge clk);
            enc <= ~enc;
            pos <= ~pos;
            pin_chk(2, ~i[0]);
        end
        // divide by two: one full input pulse flips the output once
        wr_reg(A_ROUTE0 + 8'h08, 32'h0305);
        repeat (6) @(negedge clk);
        p = line[2];
        repeat (2) begin
            @(posedge clk);
            enc <= 1'b1;
            repeat (6) @(posedge clk);
            enc <= 1'b0;
            p = ~p;
            pin_chk(2, p);
        end
    endtask
    // ==========================================================
    // main sequence and hang guard
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_brake_seq();
        t_outputs();
        t_routing();
        stop_test();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
endmodule
`default_nettype wire
